// ==== rtcb_core.sv ====
// module: serial register port, buffer/transfer registers and clock/calendar counters
`timescale 1ns/1ps
module rtcb_core import rtcb_pkg::*; #(
    parameter int TICK_CYCLES = HUNDREDTH_CYCLES
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic       spi_sclk,
    input  wire logic       spi_sdi,
    input  wire logic       spi_ce_n,
    output logic            spi_sdo,
    output logic            spi_sdo_oe,
    input  wire logic       battery_backup,
    output rtcb_time_t      time_now,
    output logic            halt_update_freeze
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_sync, ce_sync, sdi_sync, batt_sync;
    logic       sclk_d, ce_d, batt_d;

    always_ff @(posedge mclk) begin
        if (reset) begin
            sclk_sync <= 2'h0;
            ce_sync   <= 2'h3;
            sdi_sync  <= 2'h0;
            batt_sync <= 2'h0;
            sclk_d    <= 1'b0;
            ce_d      <= 1'b1;
            batt_d    <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], spi_sclk};
            ce_sync   <= {ce_sync[0], spi_ce_n};
            sdi_sync  <= {sdi_sync[0], spi_sdi};
            batt_sync <= {batt_sync[0], battery_backup};
            sclk_d    <= sclk_sync[1];
            ce_d      <= ce_sync[1];
            batt_d    <= batt_sync[1];
        end
    end

    logic sclk_rise, sclk_fall, ce_fall, ce_rise, batt_rise;
    assign sclk_rise = sclk_sync[1] & ~sclk_d;
    assign sclk_fall = ~sclk_sync[1] & sclk_d;
    assign ce_fall   = ~ce_sync[1] & ce_d;
    assign ce_rise   = ce_sync[1] & ~ce_d;
    assign batt_rise = batt_sync[1] & ~batt_d;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rtcb_time_t cnt, next_cnt;
    logic [63:0] tbuf, next_tbuf;
    logic [7:0]  wflags, next_wflags;
    logic [31:0] div, next_div;
    logic        halt, next_halt;
    logic        active, next_active;
    logic        cmd_done, next_cmd_done;
    logic        dir_wr, next_dir_wr;
    logic [2:0]  bitcnt, next_bitcnt;
    logic [5:0]  ptr, next_ptr;
    logic [7:0]  sh_in, next_sh_in;
    logic [7:0]  sh_out, next_sh_out;
    logic        mem_we;
    logic [4:0]  mem_wa;
    logic [7:0]  mem_wd, mem_rd, rd_byte, in_byte;
    logic [4:0]  mem_ra;

    assign in_byte = {sh_in[6:0], sdi_sync[1]};
    // bit 5 of the address is ignored: 32 addresses alias twice in 6 bits
    assign mem_ra  = 5'(ptr[4:0] - MEM_BASE);

    rtcb_regmem #(
        .DEPTH   (MEM_DEPTH),
        .WIDTH   (8),
        .AW      (5)
    ) u_mem (
        .mclk    (mclk),
        .wr_en   (mem_we),
        .wr_addr (mem_wa),
        .wr_data (mem_wd),
        .rd_addr (mem_ra),
        .rd_data (mem_rd)
    );

    // ------------------------------------------------------------
    // read data selection
    // ------------------------------------------------------------
    always_comb begin
        if (ptr[4:3] == 2'b00) begin
            rd_byte = tbuf[{ptr[2:0], 3'b000} +: 8];
        end else if (ptr[4:0] == ADDR_HALT_REG[4:0]) begin
            rd_byte = mem_rd;
            rd_byte[HALT_BIT] = halt;
        end else begin
            rd_byte = mem_rd;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [8:0] s;
    logic       tick;
    assign tick = (div >= 32'(TICK_CYCLES - 1));

    always_comb begin
        next_cnt      = cnt;
        next_tbuf     = tbuf;
        next_wflags   = wflags;
        next_div      = tick ? 32'h0 : div + 32'h1;
        next_halt     = halt;
        next_active   = active;
        next_cmd_done = cmd_done;
        next_dir_wr   = dir_wr;
        next_bitcnt   = bitcnt;
        next_ptr      = ptr;
        next_sh_in    = sh_in;
        next_sh_out   = sh_out;
        mem_we        = 1'b0;
        mem_wa        = 5'(ptr[4:0] - MEM_BASE);
        mem_wd        = in_byte;
        s             = 9'h000;

        // counters advance in one cycle, so a capture never sees half a carry
        if (tick && !cnt.seconds_stop[STOP_BIT]) begin
            s = rtcb_bcd_step(cnt.subsecond, BCD_99, BCD_00);
            next_cnt.subsecond = s[7:0];
            if (s[8]) begin
                s = rtcb_bcd_step({1'b0, cnt.seconds_stop[6:0]}, BCD_59, BCD_00);
                next_cnt.seconds_stop[6:0] = s[6:0];
            end
            if (s[8]) begin
                s = rtcb_bcd_step(cnt.minutes, BCD_59, BCD_00);
                next_cnt.minutes = s[7:0];
            end
            if (s[8]) begin
                s = rtcb_bcd_step({2'b00, cnt.century_hours[5:0]}, BCD_23, BCD_00);
                next_cnt.century_hours[5:0] = s[5:0];
            end
            if (s[8]) begin
                next_cnt.weekday = 8'(rtcb_bcd_step(cnt.weekday, BCD_07, BCD_01));
                s = rtcb_bcd_step(cnt.day, rtcb_month_days(cnt.month, cnt.year), BCD_01);
                next_cnt.day = s[7:0];
            end
            if (s[8]) begin
                s = rtcb_bcd_step(cnt.month, BCD_12, BCD_01);
                next_cnt.month = s[7:0];
            end
            if (s[8]) begin
                s = rtcb_bcd_step(cnt.year, BCD_99, BCD_00);
                next_cnt.year = s[7:0];
            end
            if (s[8]) begin
                next_cnt.century_hours[7:6] = 2'(cnt.century_hours[7:6] + 2'h1);
            end
        end

        if (ce_fall) begin
            next_active   = 1'b1;
            next_cmd_done = 1'b0;
            next_bitcnt   = 3'h0;
            next_wflags   = 8'h00;
            if (!halt) begin
                next_tbuf = cnt;
            end
        end else if (ce_rise) begin
            next_active = 1'b0;
            // a read leaves the next byte in the shifter, so the idle line would show it
            next_sh_out = 8'h00;
            // untouched bytes still hold the start-of-transfer copy
            if (wflags != 8'h00) begin
                next_cnt = rtcb_time_t'(tbuf & TIME_MASK);
                next_div = 32'h0;
            end
        end else if (active && sclk_rise) begin
            next_sh_in  = in_byte;
            next_bitcnt = 3'(bitcnt + 3'h1);
            if (bitcnt == 3'h7) begin
                if (!cmd_done) begin
                    next_cmd_done = 1'b1;
                    next_dir_wr   = in_byte[7];
                    next_ptr      = in_byte[5:0];
                end else begin
                    next_ptr = 6'(ptr + 6'h1);
                    if (dir_wr) begin
                        if (ptr[4:3] == 2'b00) begin
                            next_tbuf[{ptr[2:0], 3'b000} +: 8] = in_byte;
                            next_wflags[ptr[2:0]] = 1'b1;
                            next_div = 32'h0;
                        end else begin
                            mem_we = 1'b1;
                            if (ptr[4:0] == ADDR_HALT_REG[4:0]) begin
                                next_halt = in_byte[HALT_BIT];
                            end
                        end
                    end
                end
            end
        end else if (active && sclk_fall && cmd_done && !dir_wr) begin
            next_sh_out = (bitcnt == 3'h0) ? rd_byte : {sh_out[6:0], 1'b0};
        end

        // entering backup wins over a host clear in the same cycle
        if (batt_rise) begin
            next_halt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt      <= rtcb_time_t'(TIME_RESET);
            tbuf     <= 64'h0;
            wflags   <= 8'h00;
            div      <= 32'h0;
            halt     <= HALT_RESET;
            active   <= 1'b0;
            cmd_done <= 1'b0;
            dir_wr   <= 1'b0;
            bitcnt   <= 3'h0;
            ptr      <= 6'h00;
            sh_in    <= 8'h00;
            sh_out   <= 8'h00;
        end else begin
            cnt      <= next_cnt;
            tbuf     <= next_tbuf;
            wflags   <= next_wflags;
            div      <= next_div;
            halt     <= next_halt;
            active   <= next_active;
            cmd_done <= next_cmd_done;
            dir_wr   <= next_dir_wr;
            bitcnt   <= next_bitcnt;
            ptr      <= next_ptr;
            sh_in    <= next_sh_in;
            sh_out   <= next_sh_out;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign spi_sdo            = sh_out[7];
    assign spi_sdo_oe         = active & cmd_done & ~dir_wr;
    assign time_now           = cnt;
    assign halt_update_freeze = halt;

endmodule

// ==== rtcb_pkg.sv ====
// package: constants, types and helpers of the coherent buffer/transfer layer
// Functional notes
// - snapshot all counters at each transfer start while not halted
// - time write in transfer reloads counters at end
// - unwritten time bytes reload their starting values
// - writes only to 08h-1Fh and 28h-3Fh leave counters alone
// - every time register write resets divider
// - battery backup entry sets halt-update bit
// - halt-update set blocks snapshots, freezing buffers
// - host clears halt via bit 6 at 0x0C
// - time write under halt reloads frozen merged time
// - 32 addresses, BCD time, binary control
// - chip enable low starts, high ends transfer
// - first bit direction, then one ignored bit and six address bits
// - burst pointer increments, wraps 3Fh to 00h
package rtcb_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 10;
    localparam int HUNDREDTH_NS     = 10_000_000;
    localparam int HUNDREDTH_CYCLES = HUNDREDTH_NS / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [5:0] ADDR_SUBSECOND   = 6'h00;
    localparam logic [5:0] ADDR_SECONDS     = 6'h01;
    localparam logic [5:0] ADDR_MINUTES     = 6'h02;
    localparam logic [5:0] ADDR_HOURS       = 6'h03;
    localparam logic [5:0] ADDR_WEEKDAY     = 6'h04;
    localparam logic [5:0] ADDR_DAY         = 6'h05;
    localparam logic [5:0] ADDR_MONTH       = 6'h06;
    localparam logic [5:0] ADDR_YEAR        = 6'h07;
    localparam logic [5:0] ADDR_TRIM        = 6'h08;
    localparam logic [5:0] ADDR_SUPERVISOR  = 6'h09;
    localparam logic [5:0] ADDR_HALT_REG    = 6'h0C;
    localparam int         HALT_BIT         = 6;
    localparam int         STOP_BIT         = 7;
    localparam int         MEM_DEPTH        = 24;
    localparam logic [4:0] MEM_BASE         = 5'h08;
    localparam logic       HALT_RESET       = 1'b1;
    // per-byte masks of the time bytes, byte 7 in the top lane
    localparam logic [63:0] TIME_MASK       = 64'hFF1F3F07FF7FFFFF;
    localparam logic [63:0] TIME_RESET      = 64'h0001010100000000;

    // ------------------------------------------------------------
    // BCD limits
    // ------------------------------------------------------------
    localparam logic [7:0] BCD_00 = 8'h00;
    localparam logic [7:0] BCD_01 = 8'h01;
    localparam logic [7:0] BCD_07 = 8'h07;
    localparam logic [7:0] BCD_12 = 8'h12;
    localparam logic [7:0] BCD_23 = 8'h23;
    localparam logic [7:0] BCD_59 = 8'h59;
    localparam logic [7:0] BCD_99 = 8'h99;

    // byte i of the struct sits at bits 8*i+7..8*i
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] weekday;
        logic [7:0] century_hours;
        logic [7:0] minutes;
        logic [7:0] seconds_stop;
        logic [7:0] subsecond;
    } rtcb_time_t;

    // advance one BCD field; bit 8 is the carry out
    function automatic logic [8:0] rtcb_bcd_step(input logic [7:0] v, input logic [7:0] lim,
                                                 input logic [7:0] first);
        if (v >= lim) begin
            return {1'b1, first};
        end else if (v[3:0] >= 4'h9) begin
            return {1'b0, 4'(v[7:4] + 4'h1), 4'h0};
        end
        return {1'b0, v[7:4], 4'(v[3:0] + 4'h1)};
    endfunction

    function automatic logic [7:0] rtcb_month_days(input logic [7:0] month, input logic [7:0] year);
        logic leap;
        leap = (!year[4] && (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8)) ||
               (year[4] && (year[3:0] == 4'h2 || year[3:0] == 4'h6));
        case (month)
            8'h02: return leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
            default: return 8'h31;
        endcase
    endfunction

endpackage

// ==== rtcb_regmem.sv ====
// module: byte store for the non-time registers with registered read data
`timescale 1ns/1ps
module rtcb_regmem #(
    parameter int DEPTH = 24,
    parameter int WIDTH = 8,
    parameter int AW    = 5
) (
    input  wire logic             mclk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ------------------------------------------------------------
    // storage has no reset, like battery-held user bytes
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (wr_en && int'(wr_addr) < DEPTH) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
    end

endmodule

// ==== rtcb_properties.sv ====
// checker: port-level properties of the coherent buffer/transfer block
`timescale 1ns/1ps
module rtcb_properties import rtcb_pkg::*; #(
    parameter int TICK_CYCLES = HUNDREDTH_CYCLES
) (
    input wire logic       mclk,
    input wire logic       reset,
    input wire logic       spi_sclk,
    input wire logic       spi_sdi,
    input wire logic       spi_ce_n,
    input wire logic       spi_sdo,
    input wire logic       spi_sdo_oe,
    input wire logic       battery_backup,
    input wire rtcb_time_t time_now,
    input wire logic       halt_update_freeze
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    // idle_cnt saturates so write-back settling is excluded from tick checks
    logic [3:0]  idle_cnt;
    logic [3:0]  next_idle_cnt;
    logic [31:0] chg_cnt;
    logic [31:0] next_chg_cnt;
    rtcb_time_t  prev_time;

    always_comb begin
        next_idle_cnt = spi_ce_n ? ((idle_cnt == 4'hF) ? idle_cnt : idle_cnt + 4'h1) : 4'h0;
        next_chg_cnt  = (time_now != prev_time) ? 32'h0 : chg_cnt + 32'h1;
    end

    always_ff @(posedge mclk) begin
        prev_time <= time_now;
        idle_cnt  <= reset ? 4'h0 : next_idle_cnt;
        chg_cnt   <= reset ? 32'h0 : next_chg_cnt;
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    halt_reset_a: assert property ($fell(reset) |-> halt_update_freeze && time_now == TIME_RESET)
        else $error("halt or time wrong after reset");
    battery_halt_a: assert property ($rose(battery_backup) |-> ##[1:6] halt_update_freeze)
        else $error("backup entry did not set halt");
    oe_idle_a: assert property (spi_ce_n [*8] |-> !spi_sdo_oe)
        else $error("sdo driven while deselected");
    sdo_idle_a: assert property (spi_ce_n [*8] |-> !spi_sdo)
        else $error("sdo high while deselected");
    halt_clear_a: assert property ($fell(halt_update_freeze) |-> idle_cnt < 4'h8)
        else $error("halt cleared outside a transfer");
    time_fields_a: assert property (time_now.minutes[7] == 1'b0 && time_now.weekday[7:3] == 5'h00 &&
                                    time_now.day[7:6] == 2'h0 && time_now.month[7:5] == 3'h0)
        else $error("unused time bits set");
    stop_freeze_a: assert property (time_now.seconds_stop[STOP_BIT] && idle_cnt == 4'hF |=> $stable(time_now))
        else $error("counters moved while stopped");
    tick_spacing_a: assert property (time_now != prev_time && idle_cnt == 4'hF |-> chg_cnt >= TICK_CYCLES - 2)
        else $error("counter step came early");
endmodule

// ==== rtcb_spi_host.sv ====
// partner: mode 0 serial host that runs transfers into the block
`timescale 1ns/1ps
module rtcb_spi_host (
    input  wire logic mclk,
    output logic      sclk,
    output logic      sdi,
    output logic      ce_n,
    input  wire logic sdo
);
    initial begin
        sclk = 1'b0;
        sdi  = 1'b0;
        ce_n = 1'b1;
    end

    // command byte then nb data bytes; byte k sits at bits 8k+7..8k
    task automatic xfer(input logic [7:0] cmd, input int nb, input logic [63:0] wd, output logic [63:0] rd);
        logic [7:0] sh;
        rd = 64'h0;
        @(negedge mclk);
        ce_n = 1'b0;
        repeat (6) @(negedge mclk);
        // a 1 ns offset keeps every bit clock and data edge clear of both system clock edges
        #1;
        for (int k = 0; k <= nb; k++) begin
            sh = (k == 0) ? cmd : 8'(wd >> (8*k-8));
            for (int b = 7; b >= 0; b--) begin
                sdi = sh[b];
                #62.5 sclk = 1'b1;
                if (k > 0) begin
                    rd[8*k-8+b] = sdo;
                end
                #62.5 sclk = 1'b0;
            end
        end
        #62.5;
        @(negedge mclk);
        ce_n = 1'b1;
        // a released data line must not look like a held bit
        sdi = ~sdi;
        repeat (8) @(negedge mclk);
    endtask
endmodule

// ==== testbench.sv ====
// testbench: self-checking run of the coherent buffer/transfer block
`timescale 1ns/1ps
module testbench import rtcb_pkg::*;;
    localparam int          TICK = 400;
    localparam logic [63:0] T1   = 64'h99123107E359D900;
    localparam logic [63:0] T2   = 64'h99123107E330D900;
    logic        mclk;
    logic        reset;
    logic        battery_backup;
    logic        spi_sclk;
    logic        spi_sdi;
    logic        spi_ce_n;
    logic        spi_sdo;
    logic        spi_sdo_oe;
    logic        halt_update_freeze;
    rtcb_time_t  time_now;
    int          num_errors;
    int          checks_done;
    logic [63:0] rd;
    logic [63:0] r1;
    logic [63:0] mrg;

    initial mclk = 1'b0;
    always #5 mclk = ~mclk;

    rtcb_core #(.TICK_CYCLES(TICK)) DUT (.mclk(mclk), .reset(reset), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi),
        .spi_ce_n(spi_ce_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .battery_backup(battery_backup),
        .time_now(time_now), .halt_update_freeze(halt_update_freeze));
    rtcb_spi_host host (.mclk(mclk), .sclk(spi_sclk), .sdi(spi_sdi), .ce_n(spi_ce_n), .sdo(spi_sdo));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [5:0] a, input int nb, input logic [63:0] d);
        host.xfer({2'b10, a}, nb, d, rd);
    endtask
    task automatic rdb(input logic [5:0] a, input int nb);
        host.xfer({2'b00, a}, nb, 64'h0, rd);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_set_time;
        wr(ADDR_HALT_REG, 1, 64'h00);
        cyc(4);
        check("halt cleared", 64'h0, 64'(halt_update_freeze));
        wr(ADDR_SUBSECOND, 8, T1);
        cyc(10);
        check("loaded time", T1, time_now);
        rdb(ADDR_SUBSECOND, 8);
        check("burst read", T1, rd);
        wr(ADDR_MINUTES, 1, 64'h30);
        cyc(10);
        check("merged minutes", T2, time_now);
        wr(6'h1E, 2, 64'h3CA5);
        rdb(6'h3E, 3);
        check("wrapped burst", {40'h0, T2[7:0], 16'h3CA5}, rd);
        $display("test set_time done");
    endtask

    task automatic t_freeze;
        wr(ADDR_SECONDS, 1, 64'h00);
        cyc(2 * TICK);
        rdb(ADDR_SUBSECOND, 8);
        r1 = rd;
        check("running snapshot", {T2[63:16], 8'h00}, r1[63:8]);
        battery_backup = 1'b1;
        cyc(10);
        check("halt on backup", 64'h1, 64'(halt_update_freeze));
        cyc(5 * TICK);
        rdb(ADDR_SUBSECOND, 8);
        check("frozen read", r1, rd);
        rdb(ADDR_SUBSECOND, 8);
        check("frozen reread", r1, rd);
        $display("test freeze done");
    endtask

    task automatic t_halt_write;
        mrg = {r1[63:16], 8'h46, r1[7:0]};
        // seconds written with halt still set, stale time goes in on purpose
        wr(ADDR_SECONDS, 1, 64'h46);
        cyc(10);
        check("frozen merge loaded", mrg, time_now);
        cyc(TICK - 60);
        check("divider restarted", mrg, time_now);
        cyc(2 * TICK);
        wr(ADDR_TRIM, 1, 64'h5A);
        cyc(10);
        check("trim keeps counters", 64'h1, 64'(time_now[7:0] !== mrg[7:0]));
        rdb(ADDR_TRIM, 1);
        check("trim readback", 64'h5A, rd);
        $display("test halt_write done");
    endtask

    task automatic t_power_up;
        battery_backup = 1'b0;
        rdb(ADDR_SUBSECOND, 8);
        check("last access time", mrg, rd);
        rdb(ADDR_HALT_REG, 1);
        check("halt bit read", 64'h40, rd);
        wr(ADDR_HALT_REG, 1, 64'h00);
        cyc(4);
        check("halt cleared again", 64'h0, 64'(halt_update_freeze));
        rdb(ADDR_SUBSECOND, 8);
        check("present time", mrg[63:8], rd[63:8]);
        check("present subsecond", 64'h1, 64'(rd[7:0] !== mrg[7:0]));
        $display("test power_up done");
    endtask

    initial begin
        num_errors = 0;
        checks_done = 0;
        reset = 1'b1;
        battery_backup = 1'b0;
        cyc(16);
        reset = 1'b0;
        check("halt after reset", 64'h1, 64'(halt_update_freeze));
        check("time after reset", TIME_RESET, time_now);
        check("sdo enable idle", 64'h0, 64'(spi_sdo_oe));
        check("sdo idle", 64'h0, 64'(spi_sdo));
        $display("test reset done");
        cyc(3);
        t_set_time;
        t_freeze;
        t_halt_write;
        t_power_up;
        tally_and_finish;
    end

    // the whole run needs roughly 13000 cycles, so this leaves ample margin
    initial begin
        repeat (40000) @(posedge mclk);
        num_errors++;
        tally_and_finish;
    end
endmodule

bind rtcb_core rtcb_properties #(.TICK_CYCLES(TICK_CYCLES)) chk (.mclk(mclk), .reset(reset),
    .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_ce_n(spi_ce_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .battery_backup(battery_backup), .time_now(time_now), .halt_update_freeze(halt_update_freeze));
